// ==== fhb_defines.svh ====
`ifndef FHB_DEFINES_SVH
`define FHB_DEFINES_SVH

// ====================================================================
// Clock and pin timing, each time in ns with its derived cycle count.
`define FHB_CLK_NS        25
`define FHB_SETUP_NS      25
`define FHB_WE_PULSE_NS   50
`define FHB_WE_RECOVER_NS 100
`define FHB_ACCESS_NS     150
`define FHB_RECOVERY_NS   750
`define FHB_SYNC_STAGES   2

// Least times round up to whole clock cycles.
`define FHB_CEIL_CYC(ns) (((ns) + `FHB_CLK_NS - 1) / `FHB_CLK_NS)
`define FHB_SETUP_CYC      `FHB_CEIL_CYC(`FHB_SETUP_NS)
`define FHB_WE_PULSE_CYC   `FHB_CEIL_CYC(`FHB_WE_PULSE_NS)
`define FHB_WE_RECOVER_CYC `FHB_CEIL_CYC(`FHB_WE_RECOVER_NS)
`define FHB_ACCESS_CYC     `FHB_CEIL_CYC(`FHB_ACCESS_NS)
`define FHB_RECOVERY_CYC   `FHB_CEIL_CYC(`FHB_RECOVERY_NS)

// ====================================================================
// Widths and field positions of the host byte address, and the counter width.
`define FHB_ADDR_W       19
`define FHB_PIN_ADDR_W   18
`define FHB_CNT_W        6
`define FHB_BLOCK_LSB    13

`endif

// ==== fhb_pkg.sv ====
package fhb_pkg;

	// ================================================================
	// Access sequencer states.
	typedef enum logic [2:0]
	{
		ST_POWERDOWN,
		ST_RECOVER,
		ST_IDLE,
		ST_WSETUP,
		ST_WPULSE,
		ST_WHOLD,
		ST_RACCESS,
		ST_RDONE
	} fhb_state_type;

endpackage : fhb_pkg

// ==== fhb_sync.sv ====
module fhb_sync
#(
	parameter int WIDTH = 1
)
(
	// Clock, reset and enable.
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	input  wire logic             clk_en_in,
	// Asynchronous level in, synchronised level out.
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] reset_val_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	// ================================================================
	// Two stages; only the second stage reads the first.
	always_comb
	begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	// Reset loads zero; the caller's idle level is folded in by XOR so
	// that no port value ever enters a flop through reset.
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else if (clk_en_in)
		begin
			meta_r <= meta_nxt ^ reset_val_in;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r ^ reset_val_in;

endmodule : fhb_sync

// ==== fhb_host.sv ====
// Function
// - Commands go out on the low byte; status reads return the low byte (word-mode reads return the whole word).
// - Chip select is driven low around every access.
// - Address and data held stable across the write strobe rising edge.
// - After releasing reset power-down, wait 750 ns before any access.
// - Writes and erases are two-write command sequences from the user.
// - Next request waits for completion, except bypass for suspend.
`include "fhb_defines.svh"

module fhb_host
	import fhb_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic                       clk_in,
	input  wire logic                       reset_n_in,
	input  wire logic                       clk_en_in,
	// User request port.
	input  wire logic                       req_valid_in,
	input  wire logic                       req_write_in,
	input  wire logic                       req_bypass_in,
	input  wire logic                       word_mode_in,
	input  wire logic [`FHB_ADDR_W-1:0]     req_addr_in,
	input  wire logic [15:0]                req_wdata_in,
	input  wire logic                       powerdown_in,
	output logic                            req_ready_out,
	output logic [15:0]                     rdata_out,
	output logic                            rdata_valid_out,
	output logic                            busy_out,
	// Flash pins.
	output logic                            flash_ce_n_out,
	output logic                            flash_oe_n_out,
	output logic                            flash_we_n_out,
	output logic                            reset_powerdown_n_out,
	output logic                            flash_word_mode_out,
	output logic [`FHB_PIN_ADDR_W-1:0]      flash_addr_out,
	input  wire logic [15:0]                flash_dq_in,
	output logic [15:0]                     flash_dq_out,
	output logic                            flash_dq_lo_oe_out,
	output logic                            flash_dq_hi_oe_out,
	output logic                            flash_dq15_oe_out,
	input  wire logic                       ready_busy_n_in
);

	fhb_state_type                state_r, state_nxt;
	logic [`FHB_CNT_W-1:0]        cnt_r, cnt_nxt;
	logic                         ce_n_r, ce_n_nxt;
	logic                         oe_n_r, oe_n_nxt;
	logic                         we_n_r, we_n_nxt;
	logic                         rp_n_r, rp_n_nxt;
	logic                         byte_r, byte_nxt;
	logic [`FHB_PIN_ADDR_W-1:0]   addr_r, addr_nxt;
	logic [15:0]                  dq_r, dq_nxt;
	logic                         lo_oe_r, lo_oe_nxt;
	logic                         hi_oe_r, hi_oe_nxt;
	logic                         dq15_oe_r, dq15_oe_nxt;
	logic [15:0]                  rdata_r, rdata_nxt;
	logic                         rvalid_r, rvalid_nxt;
	logic                         ready_r, ready_nxt;
	logic                         busy_r, busy_nxt;
	logic [15:0]                  dq_s;
	logic                         rb_s;
	logic                         take;

	// ================================================================
	// Pin inputs cross in through two flops each.
	fhb_sync #(.WIDTH(16)) u_dq_sync
	(
		.clk_in       (clk_in),
		.reset_n_in   (reset_n_in),
		.clk_en_in    (clk_en_in),
		.async_in     (flash_dq_in),
		.reset_val_in (16'h0000),
		.sync_out     (dq_s)
	);

	// The pull-up makes a released pin read as ready.
	fhb_sync #(.WIDTH(1)) u_rb_sync
	(
		.clk_in       (clk_in),
		.reset_n_in   (reset_n_in),
		.clk_en_in    (clk_en_in),
		.async_in     (ready_busy_n_in),
		.reset_val_in (1'b1),
		.sync_out     (rb_s)
	);

	// ================================================================
	// A request is taken in idle when the device is ready, or when the
	// user marks it as a bypass write such as an erase suspend.
	assign take = (state_r == ST_IDLE) && req_valid_in
		&& (ready_r || (req_bypass_in && req_write_in));

	// ================================================================
	// Access sequencer: next values of every pin and status flop.
	always_comb
	begin
		state_nxt   = state_r;
		cnt_nxt     = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
		ce_n_nxt    = ce_n_r;
		oe_n_nxt    = oe_n_r;
		we_n_nxt    = we_n_r;
		rp_n_nxt    = rp_n_r;
		byte_nxt    = byte_r;
		addr_nxt    = addr_r;
		dq_nxt      = dq_r;
		lo_oe_nxt   = lo_oe_r;
		hi_oe_nxt   = hi_oe_r;
		dq15_oe_nxt = dq15_oe_r;
		rdata_nxt   = rdata_r;
		rvalid_nxt  = 1'b0;
		unique case (state_r)
			ST_POWERDOWN:
			begin
				if (!powerdown_in)
				begin
					rp_n_nxt  = 1'b1;
					cnt_nxt   = `FHB_CNT_W'(`FHB_RECOVERY_CYC - 1);
					state_nxt = ST_RECOVER;
				end
			end
			ST_RECOVER:
			begin
				if (cnt_r == '0)
					state_nxt = ST_IDLE;
			end
			ST_IDLE:
			begin
				// Width may only change between accesses.
				byte_nxt = word_mode_in;
				if (take)
				begin
					ce_n_nxt = 1'b0;
					// Word mode uses the word address; byte mode shifts it
					// and puts the byte bit on data line 15.
					addr_nxt = word_mode_in
						? req_addr_in[`FHB_PIN_ADDR_W-1:0]
						: req_addr_in[`FHB_ADDR_W-1:1];
					dq15_oe_nxt = !word_mode_in || req_write_in;
					if (req_write_in)
					begin
						// Byte mode: low byte plus the byte bit on line 15, lines 8 to 14 undriven.
						dq_nxt = word_mode_in ? req_wdata_in
							: {req_addr_in[0], 7'h00, req_wdata_in[7:0]};
						lo_oe_nxt = 1'b1;
						hi_oe_nxt = word_mode_in;
						cnt_nxt   = `FHB_CNT_W'(`FHB_SETUP_CYC - 1);
						state_nxt = ST_WSETUP;
					end
					else
					begin
						dq_nxt    = {req_addr_in[0], 15'h0000};
						oe_n_nxt  = 1'b0;
						cnt_nxt   = `FHB_CNT_W'(`FHB_ACCESS_CYC
							+ `FHB_SYNC_STAGES - 1);
						state_nxt = ST_RACCESS;
					end
				end
			end
			ST_WSETUP:
			begin
				if (cnt_r == '0)
				begin
					we_n_nxt  = 1'b0;
					cnt_nxt   = `FHB_CNT_W'(`FHB_WE_PULSE_CYC - 1);
					state_nxt = ST_WPULSE;
				end
			end
			ST_WPULSE:
			begin
				// Data and address stay driven past the rising edge.
				if (cnt_r == '0)
				begin
					we_n_nxt  = 1'b1;
					cnt_nxt   = `FHB_CNT_W'(`FHB_WE_RECOVER_CYC - 1);
					state_nxt = ST_WHOLD;
				end
			end
			ST_WHOLD:
			begin
				// The hold also lets a fresh busy reach the synchroniser
				// before the next request can look at it.
				if (cnt_r == '0)
				begin
					ce_n_nxt    = 1'b1;
					lo_oe_nxt   = 1'b0;
					hi_oe_nxt   = 1'b0;
					dq15_oe_nxt = 1'b0;
					state_nxt   = ST_IDLE;
				end
			end
			ST_RACCESS:
			begin
				if (cnt_r == '0)
				begin
					// Word mode returns the whole word; byte mode keeps the low byte only.
					rdata_nxt   = byte_r ? dq_s : {8'h00, dq_s[7:0]};
					rvalid_nxt  = 1'b1;
					oe_n_nxt    = 1'b1;
					ce_n_nxt    = 1'b1;
					dq15_oe_nxt = 1'b0;
					state_nxt   = ST_RDONE;
				end
			end
			ST_RDONE:
			begin
				// One idle cycle lets the device release the bus.
				state_nxt = ST_IDLE;
			end
		endcase
		// Power-down wins over any access in flight.
		if (powerdown_in)
		begin
			rp_n_nxt    = 1'b0;
			ce_n_nxt    = 1'b1;
			oe_n_nxt    = 1'b1;
			we_n_nxt    = 1'b1;
			lo_oe_nxt   = 1'b0;
			hi_oe_nxt   = 1'b0;
			dq15_oe_nxt = 1'b0;
			rvalid_nxt  = 1'b0;
			state_nxt   = ST_POWERDOWN;
		end
		busy_nxt  = !rb_s;
		ready_nxt = (state_nxt == ST_IDLE) && rb_s;
	end

	// ================================================================
	// Register every output; reset holds the device in power-down.
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			state_r   <= ST_POWERDOWN;
			cnt_r     <= '0;
			ce_n_r    <= 1'b1;
			oe_n_r    <= 1'b1;
			we_n_r    <= 1'b1;
			rp_n_r    <= 1'b0;
			byte_r    <= 1'b0;
			addr_r    <= '0;
			dq_r      <= 16'h0000;
			lo_oe_r   <= 1'b0;
			hi_oe_r   <= 1'b0;
			dq15_oe_r <= 1'b0;
			rdata_r   <= 16'h0000;
			rvalid_r  <= 1'b0;
			ready_r   <= 1'b0;
			busy_r    <= 1'b0;
		end
		else if (clk_en_in)
		begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			ce_n_r    <= ce_n_nxt;
			oe_n_r    <= oe_n_nxt;
			we_n_r    <= we_n_nxt;
			rp_n_r    <= rp_n_nxt;
			byte_r    <= byte_nxt;
			addr_r    <= addr_nxt;
			dq_r      <= dq_nxt;
			lo_oe_r   <= lo_oe_nxt;
			hi_oe_r   <= hi_oe_nxt;
			dq15_oe_r <= dq15_oe_nxt;
			rdata_r   <= rdata_nxt;
			rvalid_r  <= rvalid_nxt;
			ready_r   <= ready_nxt;
			busy_r    <= busy_nxt;
		end
	end

	assign req_ready_out         = ready_r;
	assign rdata_out             = rdata_r;
	assign rdata_valid_out       = rvalid_r;
	assign busy_out              = busy_r;
	assign flash_ce_n_out        = ce_n_r;
	assign flash_oe_n_out        = oe_n_r;
	assign flash_we_n_out        = we_n_r;
	assign reset_powerdown_n_out = rp_n_r;
	assign flash_word_mode_out   = byte_r;
	assign flash_addr_out        = addr_r;
	assign flash_dq_out          = dq_r;
	assign flash_dq_lo_oe_out    = lo_oe_r;
	assign flash_dq_hi_oe_out    = hi_oe_r;
	assign flash_dq15_oe_out     = dq15_oe_r;

	// ================================================================
	// Checks. The recovery counter only helps the checks.
	logic [`FHB_CNT_W-1:0] since_rp_r;

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in || !rp_n_r)
			since_rp_r <= '0;
		else if (clk_en_in && since_rp_r != '1)
			since_rp_r <= since_rp_r + 1'b1;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	a_x8_upper_float: assert property (!byte_r |-> !hi_oe_r)
		else $error("Upper data byte driven in byte mode.");
	a_x8_byte_addr: assert property (!byte_r && !ce_n_r
		|=> dq15_oe_r || ce_n_r || !rp_n_r)
		else $error("Byte address bit not driven in byte mode.");
	a_x16_line15: assert property (byte_r && !oe_n_r |-> !dq15_oe_r)
		else $error("Line 15 driven during a word-mode read.");
	// In byte mode line 15 is an address input, so it may stay driven.
	a_no_contention: assert property ((lo_oe_r || hi_oe_r
		|| (dq15_oe_r && byte_r)) |-> oe_n_r)
		else $error("Data driven while output enable is low.");
	a_ce_frames: assert property ((!oe_n_r || !we_n_r) |-> !ce_n_r)
		else $error("Strobe active without chip select.");
	a_we_edge_data: assert property ($rose(we_n_r) && rp_n_r
		|-> lo_oe_r && !ce_n_r && $stable(addr_r) && $stable(dq_r))
		else $error("Data or address moved at write strobe edge.");
	a_pd_strobes: assert property (!rp_n_r |-> ce_n_r && we_n_r && oe_n_r)
		else $error("Strobe active during power-down.");
	a_recovery_wait: assert property (ready_r
		|-> rp_n_r && since_rp_r >= `FHB_CNT_W'(`FHB_RECOVERY_CYC))
		else $error("Access offered before recovery time.");
	a_busy_blocks: assert property (ready_r |-> !busy_r)
		else $error("Ready offered while device busy.");

	c_write: cover property ($rose(we_n_r) && byte_r);
	c_read_x8: cover property (rvalid_r && !byte_r);
	c_powerdown: cover property ($rose(rp_n_r));
	c_bypass: cover property (take && busy_r);

endmodule : fhb_host

// ==== fhb_flash_model.sv ====
module fhb_flash_model
(
	// Clock and answer delays.
	input  wire logic        clk_in,
	input  wire logic [7:0]  busy_cyc_in,
	input  wire logic [2:0]  acc_cyc_in,
	// Device pins.
	input  wire logic        ce_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        we_n_in,
	input  wire logic        rp_n_in,
	input  wire logic        word_mode_in,
	input  wire logic [17:0] addr_in,
	input  wire logic [15:0] dq_in,
	input  wire logic [15:0] dq_oe_in,
	output logic      [15:0] dq_out,
	output logic             rb_low_out,
	output logic             err_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Byte array; unwritten bytes read as erased.
	logic [7:0]  mem [logic [18:0]];
	logic [18:0] pend_a;
	logic [18:0] ra;
	logic [15:0] pend_d;
	logic        pend_w;
	int          busy;
	int          acc;
	realtime     t_rp;

	function automatic logic [7:0] rd(input logic [18:0] a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction : rd

	initial
	begin
		err_out = 1'b0;
		busy = 0;
		acc = 0;
		t_rp = 0.0;
		dq_out = 16'h5A5A;
	end

	// Open drain: pulled low only while an operation runs.
	assign rb_low_out = (busy != 0) && rp_n_in;

	// Address and data are taken on the strobe's rising edge.
	always @(posedge we_n_in)
		if (!ce_n_in && rp_n_in)
		begin
			if (busy != 0)
				err_out = 1'b1;
			pend_a = word_mode_in ? {addr_in, 1'b0} : {addr_in, dq_in[15]};
			pend_d = dq_in;
			pend_w = word_mode_in;
			busy = int'(busy_cyc_in) + 1;
		end

	// Selecting the part too soon after wake-up is a host fault.
	always @(posedge rp_n_in)
		t_rp = $realtime;
	always @(negedge ce_n_in)
		if (rp_n_in === 1'b1 && $realtime - t_rp < 750.0)
			err_out = 1'b1;

	// Operation timer; power-down discards the pending write.
	always @(posedge clk_in)
	begin
		if (!rp_n_in)
			busy = 0;
		else if (busy == 1)
		begin
			mem[pend_a] = pend_d[7:0];
			if (pend_w)
				mem[pend_a + 19'h1] = pend_d[15:8];
		end
		if (busy != 0)
			busy--;
		acc = (!ce_n_in && !oe_n_in) ? acc + 1 : 0;
	end

	// Released lines toggle so a stale value is never mistaken for data.
	always @(negedge clk_in)
	begin
		if (!ce_n_in && !oe_n_in && (|dq_oe_in[14:0]
			|| (word_mode_in && dq_oe_in[15])))
			err_out = 1'b1;
		ra = word_mode_in ? {addr_in, 1'b0} : {addr_in, dq_in[15]};
		if (!ce_n_in && !oe_n_in && rp_n_in && acc > int'(acc_cyc_in))
			dq_out = {word_mode_in ? rd(ra + 19'h1) : ~dq_out[15:8], rd(ra)};
		else
			dq_out = ~dq_out;
	end
endmodule : fhb_flash_model

// ==== tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Bench signals.
	logic        clk;
	logic        rst_n;
	logic        valid;
	logic        write;
	logic        wmode;
	logic        pdown;
	logic        bypass;
	logic [18:0] addr;
	logic [15:0] wdata;
	logic        ready;
	logic        rvalid;
	logic        busy;
	logic [15:0] rdata;
	logic        ce_n;
	logic        oe_n;
	logic        we_n;
	logic        rp_n;
	logic        fwm;
	logic [17:0] faddr;
	logic [15:0] dq_i;
	logic [15:0] dq_o;
	logic        lo_oe;
	logic        hi_oe;
	logic        oe15;
	logic        rb_low;
	logic        ferr;
	logic [7:0]  busy_cyc;
	logic [2:0]  acc_cyc;
	logic [15:0] exp_q [$];
	logic [15:0] d;
	logic [18:0] a;
	int          miscompares;
	int          tests_run;
	int          n;

	fhb_host i_dut (.clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
		.req_valid_in(valid), .req_write_in(write), .req_bypass_in(bypass),
		.word_mode_in(wmode), .req_addr_in(addr), .req_wdata_in(wdata),
		.powerdown_in(pdown), .req_ready_out(ready), .rdata_out(rdata),
		.rdata_valid_out(rvalid), .busy_out(busy), .flash_ce_n_out(ce_n),
		.flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
		.reset_powerdown_n_out(rp_n), .flash_word_mode_out(fwm),
		.flash_addr_out(faddr), .flash_dq_in(dq_i), .flash_dq_out(dq_o),
		.flash_dq_lo_oe_out(lo_oe), .flash_dq_hi_oe_out(hi_oe),
		.flash_dq15_oe_out(oe15), .ready_busy_n_in(!rb_low));

	fhb_flash_model i_flash (.clk_in(clk), .busy_cyc_in(busy_cyc),
		.acc_cyc_in(acc_cyc), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
		.rp_n_in(rp_n), .word_mode_in(fwm), .addr_in(faddr), .dq_in(dq_o),
		.dq_oe_in({oe15, {7{hi_oe}}, {8{lo_oe}}}), .dq_out(dq_i),
		.rb_low_out(rb_low), .err_out(ferr));

	// 40 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic fail(input string msg);
		miscompares++;
		$display("MISMATCH at %0t: %s", $time, msg);
	endtask : fail

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// Waits for ready, offers one request, drops it at the take edge.
	task automatic request(input logic wr, input logic [18:0] ra,
		input logic [15:0] rd);
		int k;
		k = 0;
		@(posedge clk);
		#1;
		while (ready !== 1'b1 && k < 2000)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= 2000)
			fail("ready never returned");
		@(posedge clk);
		valid <= 1'b1;
		write <= wr;
		addr <= ra;
		wdata <= rd;
		busy_cyc <= 8'($urandom_range(20, 1));
		// Four cycles at most keeps the data inside the 150 ns access.
		acc_cyc <= 3'($urandom_range(4, 0));
		@(posedge clk);
		valid <= 1'b0;
		addr <= 19'($urandom);
		wdata <= 16'($urandom);
	endtask : request

	task automatic read(input logic [18:0] ra, input logic [15:0] e);
		request(1'b0, ra, 16'($urandom));
		exp_q.push_back(e);
	endtask : read

	// Result watcher and pin checks, sampled where outputs are settled.
	always @(negedge clk)
	begin
		if (rvalid === 1'b1)
		begin
			tests_run++;
			if (exp_q.size() == 0)
				fail("read data not expected");
			else if (rdata !== exp_q.pop_front())
				fail("read data differs");
		end
		if (we_n === 1'b0)
		begin
			tests_run++;
			if (ce_n !== 1'b0 || oe_n !== 1'b1 || hi_oe !== fwm)
				fail("pins wrong during write strobe");
		end
		if (oe_n === 1'b0 && (ce_n !== 1'b0 || lo_oe !== 1'b0 || hi_oe !== 1'b0))
			fail("pins wrong during read");
	end

	// Watchdog well beyond the expected run length.
	initial
	begin
		#1000000;
		fail("run timed out");
		end_sim();
	end

	// Main sequence.
	initial
	begin
		rst_n = 1'b0;
		valid = 1'b0;
		write = 1'b0;
		wmode = 1'b1;
		pdown = 1'b1;
		bypass = 1'b0;
		addr = 19'h0;
		wdata = 16'h0;
		busy_cyc = 8'h01;
		acc_cyc = 3'h0;
		miscompares = 0;
		tests_run = 0;
		void'($urandom(32'h6A84));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		pdown <= 1'b0;
		// Recovery after wake-up is at least 750 ns, that is 30 cycles.
		n = 0;
		while (rp_n !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		while (ready !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		tests_run++;
		if (n < 30 || n >= 200)
			fail("recovery time wrong");
		// Word writes, top word of the last block first.
		for (int i = 0; i < 5; i++)
		begin
			a = (i == 0) ? 19'h3FFFF : {1'b0, 18'($urandom)};
			d = 16'($urandom);
			request(1'b1, a, d);
			read(a, d);
		end
		// Byte writes of both halves, three byte reads, then one word read.
		wmode <= 1'b0;
		a = {18'($urandom), 1'b0};
		d = 16'($urandom);
		request(1'b1, a, {8'($urandom), d[7:0]});
		request(1'b1, a + 19'h1, {8'($urandom), d[15:8]});
		read(a + 19'h1, {8'h00, d[15:8]});
		read(a, {8'h00, d[7:0]});
		read(a, {8'h00, d[7:0]});
		wmode <= 1'b1;
		read({1'b0, a[18:1]}, d);
		// A long write aborted by deep power-down.
		request(1'b1, 19'h01234, 16'($urandom));
		busy_cyc <= 8'hC8;
		n = 0;
		while (busy !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		tests_run++;
		if (busy !== 1'b1 || ready !== 1'b0)
			fail("busy not reported");
		// A bypass flag on a read must not get it past a busy device.
		@(posedge clk);
		valid <= 1'b1;
		write <= 1'b0;
		bypass <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		tests_run++;
		if (ce_n !== 1'b1)
			fail("read taken while device busy");
		@(posedge clk);
		valid <= 1'b0;
		bypass <= 1'b0;
		pdown <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		tests_run++;
		if (rp_n !== 1'b0 || ce_n !== 1'b1 || busy !== 1'b0)
			fail("power-down did not abort");
		@(posedge clk);
		pdown <= 1'b0;
		read(19'h01234, 16'hFFFF);
		read({1'b0, a[18:1]}, d);
		repeat (20) @(posedge clk);
		tests_run++;
		if (ferr !== 1'b0 || exp_q.size() != 0)
			fail("flash saw a protocol fault");
		end_sim();
	end
endmodule : tb_top
